// File: bench/serial_ctrl_model.sv
// Controller model for the serial frame of the pin unit.
// Assumes ref_clk at 25 MHz; one serial clock is nine ref_clk periods.
`timescale 1ns/1ns
`default_nettype none
module serial_ctrl_model (
  input wire logic ref_clk,
  output logic serial_clk_pin,
  output logic serial_frame_sync_pin,
  output logic serial_data_in_pin,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_oe
);
  // ****************************************
  // Captured answer of the last frame
  // ****************************************
  logic [47:0] out_bits;
  logic [47:0] oe_bits;

  initial begin
    serial_clk_pin = 1'b0;
    serial_frame_sync_pin = 1'b0;
    serial_data_in_pin = 1'b0;
  end

  // ****************************************
  // One frame plus trailing clocks
  // ****************************************
  task automatic run_frame(input logic [15:0] ctrl, input logic [15:0] wdata,
                           output logic [15:0] rdata);
    logic [47:0] tx;
    tx = {ctrl, wdata, ~wdata};
    // Trailing clocks let the write land before the task returns
    for (int i = 0; i < 68; i++) begin
      @(posedge ref_clk);
      serial_clk_pin <= 1'b1;
      serial_frame_sync_pin <= (i == 0);
      serial_data_in_pin <= (i < 48) ? tx[47-i] : ~serial_data_in_pin;
      repeat (4) @(posedge ref_clk);
      serial_clk_pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      if (i < 48) begin
        // Released line floats to its pull-up level
        out_bits[47-i] = serial_data_out_oe ? serial_data_out_pin : 1'b1;
        oe_bits[47-i] = serial_data_out_oe;
      end
    end
    // Clock stands still between frames
    serial_data_in_pin <= ~serial_data_in_pin;
    rdata = out_bits[15:0];
  endtask
endmodule
`default_nettype wire

// File: bench/test_gpio_edge_interrupt_unit.sv
// Self-checking bench for the pin and edge interrupt unit.
// Assumes the serial controller model and a 25 MHz reference clock.
`timescale 1ns/1ns
`default_nettype none
module test_gpio_edge_interrupt_unit;
  import gpio_edge_pkg::*;
  logic ref_clk, srst, sclk, fsync, sdin, sdout, sdout_oe;
  logic [9:0] ext_pins, gpio_out, gpio_oe, pad;
  logic [4:0] src;
  logic [15:0] exp_reg [0:3];
  logic [15:0] exp_stat, last_clr, old_src, d, c;
  logic [3:0] a;
  integer seed, error_cnt, n_tests;

  assign pad = (gpio_oe & gpio_out) | (~gpio_oe & ext_pins);

  gpio_edge_interrupt_unit i_dut (
    .ref_clk(ref_clk), .srst(srst), .serial_clk_pin(sclk),
    .serial_frame_sync_pin(fsync), .serial_data_in_pin(sdin),
    .serial_data_out_pin(sdout), .serial_data_out_oe(sdout_oe),
    .gpio_in(pad), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .conv_done(src[0]), .touch_x_plus_line(src[1]),
    .touch_x_minus_line(src[2]), .tel_overload(src[3]),
    .snd_overload(src[4])
  );

  serial_ctrl_model i_ctrl (
    .ref_clk(ref_clk), .serial_clk_pin(sclk), .serial_frame_sync_pin(fsync),
    .serial_data_in_pin(sdin), .serial_data_out_pin(sdout),
    .serial_data_out_oe(sdout_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Expectation helpers
  // ****************************************
  function automatic logic [15:0] src_vec();
    logic [9:0] p;
    p = (exp_reg[1][9:0] & exp_reg[0][9:0]) | (~exp_reg[1][9:0] & ext_pins);
    src_vec = {src, 1'b0, p};
  endfunction

  function automatic logic [15:0] exp_read(input logic [3:0] ad);
    case (ad)
      4'h0: exp_read = src_vec() & PIN_MASK;
      4'h1, 4'h2, 4'h3: exp_read = exp_reg[ad];
      4'h4: exp_read = exp_stat;
      default: exp_read = 16'h0000;
    endcase
  endfunction

  task automatic note_src();
    logic [15:0] n;
    n = src_vec();
    exp_stat |= ((n & ~old_src & exp_reg[2]) | (old_src & ~n & exp_reg[3]));
    old_src = n;
  endtask

  task automatic compare16(input logic [15:0] got, input logic [15:0] exp,
                           input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ****************************************
  // Frame tasks
  // ****************************************
  task automatic xfer(input logic [15:0] ctrl, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic d15;
    d15 = exp_reg[1][15];
    i_ctrl.run_frame(ctrl, wdata, rdata);
    compare16(i_ctrl.oe_bits[31:16], {16{d15}}, "word two enable");
    compare16(i_ctrl.out_bits[31:16], {16{~d15}}, "word two");
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] wd);
    logic [15:0] unused;
    xfer({12'h000, ad}, wd, unused);
    case (ad)
      4'h0: exp_reg[0] = wd & PIN_MASK;
      4'h1: exp_reg[1] = wd & DIR_MASK;
      4'h2, 4'h3: exp_reg[ad] = wd & EDGE_MASK;
      4'h4: begin
        exp_stat &= ~(wd & ~last_clr);
        last_clr = wd;
      end
      default: ;
    endcase
    note_src();
  endtask

  task automatic rd(input logic [3:0] ad);
    logic [15:0] got;
    xfer({1'b1, 11'h000, ad}, 16'($random(seed)), got);
    compare16(got, exp_read(ad), "read data");
    compare16(i_ctrl.oe_bits[15:0], 16'hFFFF, "word three enable");
  endtask

  task automatic change_src();
    @(posedge ref_clk);
    ext_pins <= 10'($random(seed));
    src <= 5'($random(seed));
    repeat (8) @(posedge ref_clk);
    note_src();
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 24748;
    error_cnt = 0;
    n_tests = 0;
    srst = 1'b1;
    src = 5'h00;
    ext_pins = 10'($random(seed));
    exp_stat = 16'h0000;
    last_clr = 16'h0000;
    for (int i = 0; i < 4; i++) exp_reg[i] = 16'h0000;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    old_src = src_vec();
    compare16({6'h00, gpio_oe}, 16'h0000, "reset enable");
    for (int i = 0; i < 6; i++) rd(4'(i));
    for (int k = 0; k < 12; k++) begin
      a = (k < 6) ? 4'(k) : 4'($unsigned($random(seed)) % 6);
      d = (k < 6) ? 16'hFFFF : 16'($random(seed));
      wr(a, d);
      compare16({6'h00, gpio_oe}, {6'h00, exp_reg[1][9:0]}, "pin oe");
      compare16({6'h00, gpio_out}, {6'h00, exp_reg[0][9:0]}, "pin out");
      rd(a);
      rd(4'h0);
    end
    wr(4'h1, 16'h0000);
    wr(4'h4, 16'h0000);
    for (int r = 0; r < 16; r++) begin
      if (r % 4 == 0) begin
        wr(4'h2, 16'($random(seed)));
        wr(4'h3, 16'($random(seed)));
      end
      change_src();
      rd(4'h4);
      c = (r % 3 == 2) ? last_clr : 16'($random(seed));
      wr(4'h4, c);
      rd(4'h4);
    end
    complete_run();
  end

  initial begin
    repeat (80000) @(posedge ref_clk);
    error_cnt++;
    $display("Error at %0t: run timed out", $time);
    complete_run();
  end
endmodule
`default_nettype wire

// File: src/gpio_edge_interrupt_unit.sv
// Pin data, direction and edge interrupt registers on the serial bus.
// Assumes all pins and the serial bus clock are asynchronous to ref_clk.
//
// How it works
// - Output pins drive the last written pin data bit.
// - Reading pin data returns live pin levels.
// - Direction bit one makes output; all reset to inputs.
// - Direction bit 15 drives data out low in word two, else released.
// - Rising enable bits 0-9 let pin rises set pin status.
// - Falling enable bits 0-9 let pin falls set pin status.
// - Bit 11 enables converter-done rise or fall interrupts.
// - Bit 12 enables touch plus line rise or fall interrupts.
// - Bit 13 enables touch minus line rise or fall interrupts.
// - Bit 14 enables telecom overload rise or fall interrupts.
// - Bit 15 enables audio overload rise or fall interrupts.
// - Status bits 0-9 read back pending pin interrupts.
// - Clear happens only on a zero-to-one written clear bit.
// - Status bit 11 reports converter-done; rising clear write clears it.
// - Status bit 12 reports touch plus; rising clear write clears it.
// - Status bit 13 reports touch minus; rising clear write clears it.
// - Status bits 14,15 report overloads; rising clear write clears them.
// - Writes apply 65 serial clocks after frame sync falls, or at the next frame sync fall if sooner.
`timescale 1ns/1ns
`default_nettype none
module gpio_edge_interrupt_unit
  import gpio_edge_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic serial_clk_pin,
  input wire logic serial_frame_sync_pin,
  input wire logic serial_data_in_pin,
  output var logic serial_data_out_pin,
  output var logic serial_data_out_oe,
  input wire logic [PIN_COUNT-1:0] gpio_in,
  output logic [PIN_COUNT-1:0] gpio_out,
  output logic [PIN_COUNT-1:0] gpio_oe,
  input wire logic conv_done,
  input wire logic touch_x_plus_line,
  input wire logic touch_x_minus_line,
  input wire logic tel_overload,
  input wire logic snd_overload
);

  typedef enum logic {FRAME_IDLE, FRAME_ACTIVE} frame_e;

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [17:0] raw_in;
  logic [17:0] sync_in;
  logic sclk_s;
  logic fsync_s;
  logic din_s;
  logic [PIN_COUNT-1:0] pins_s;

  assign raw_in = {snd_overload, tel_overload, touch_x_minus_line,
                   touch_x_plus_line, conv_done, gpio_in,
                   serial_data_in_pin, serial_frame_sync_pin,
                   serial_clk_pin};

  sync2 #(.WIDTH(18)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .d(raw_in),
    .q(sync_in)
  );

  assign sclk_s = sync_in[0];
  assign fsync_s = sync_in[1];
  assign din_s = sync_in[2];
  assign pins_s = sync_in[12:3];

  // ****************************************
  // Serial clock and sync edges
  // ****************************************
  logic sclk_prev_r;
  logic fsync_prev_r;
  logic sclk_fall;
  logic sclk_rise;
  logic fsync_fall;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_prev_r <= 1'b0;
      fsync_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_s;
      fsync_prev_r <= fsync_s;
    end
  end

  assign sclk_fall = sclk_prev_r & ~sclk_s;
  assign sclk_rise = ~sclk_prev_r & sclk_s;
  assign fsync_fall = fsync_prev_r & ~fsync_s;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] pin_data_r;
  logic [15:0] pin_direction_r;
  logic [15:0] rising_edge_enable_r;
  logic [15:0] falling_edge_enable_r;
  logic [15:0] status_r;
  logic [15:0] clr_last_r;
  logic [15:0] clr_pulse;
  logic apply_wr;
  logic [3:0] wr_addr_r;
  logic [15:0] wr_data_r;

  assign gpio_out = pin_data_r[PIN_COUNT-1:0];
  assign gpio_oe = pin_direction_r[PIN_COUNT-1:0];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_data_r <= RST_PIN_DATA;
      pin_direction_r <= RST_PIN_DIRECTION;
      rising_edge_enable_r <= RST_RISING_EDGE_ENABLE;
      falling_edge_enable_r <= RST_FALLING_EDGE_ENABLE;
      clr_last_r <= RST_INTERRUPT_STATUS;
    end else if (apply_wr) begin
      case (wr_addr_r)
        ADDR_PIN_DATA: pin_data_r <= wr_data_r & PIN_MASK;
        ADDR_PIN_DIRECTION: pin_direction_r <= wr_data_r & DIR_MASK;
        ADDR_RISING_EDGE_ENABLE: begin
          rising_edge_enable_r <= wr_data_r & EDGE_MASK;
        end
        ADDR_FALLING_EDGE_ENABLE: begin
          falling_edge_enable_r <= wr_data_r & EDGE_MASK;
        end
        ADDR_INTERRUPT_CLEAR_STATUS: clr_last_r <= wr_data_r & EDGE_MASK;
        default: clr_last_r <= clr_last_r;
      endcase
    end
  end

  // ****************************************
  // Edge detection and sticky status
  // ****************************************
  logic [15:0] src_vec;
  logic [15:0] src_prev_r;
  logic [15:0] rise_ev;
  logic [15:0] fall_ev;

  always_comb begin
    src_vec = 16'h0000;
    src_vec[PIN_COUNT-1:0] = pins_s;
    src_vec[BIT_CONV_DONE] = sync_in[13];
    src_vec[BIT_TOUCH_XPOS] = sync_in[14];
    src_vec[BIT_TOUCH_XNEG] = sync_in[15];
    src_vec[BIT_TEL_OVERLOAD] = sync_in[16];
    src_vec[BIT_SND_OVERLOAD] = sync_in[17];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      src_prev_r <= 16'h0000;
    end else begin
      src_prev_r <= src_vec;
    end
  end

  assign rise_ev = src_vec & ~src_prev_r & rising_edge_enable_r;
  assign fall_ev = ~src_vec & src_prev_r & falling_edge_enable_r;

  always_comb begin
    clr_pulse = 16'h0000;
    if (apply_wr && wr_addr_r == ADDR_INTERRUPT_CLEAR_STATUS) begin
      clr_pulse = wr_data_r & ~clr_last_r & EDGE_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= RST_INTERRUPT_STATUS;
    end else begin
      status_r <= (status_r & ~clr_pulse) | rise_ev | fall_ev;
    end
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  function automatic logic [15:0] read_word(input logic [3:0] addr);
    logic [15:0] w;
    w = 16'h0000;
    case (addr)
      ADDR_PIN_DATA: w = {6'h00, pins_s};
      ADDR_PIN_DIRECTION: w = pin_direction_r;
      ADDR_RISING_EDGE_ENABLE: w = rising_edge_enable_r;
      ADDR_FALLING_EDGE_ENABLE: w = falling_edge_enable_r;
      ADDR_INTERRUPT_CLEAR_STATUS: w = status_r;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // ****************************************
  // Frame receiver
  // ****************************************
  frame_e state_r;
  logic [5:0] bit_idx_r;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] rd_data_r;
  logic wr_pend_r;
  logic wr_last;

  assign shift_nxt = {shift_r[14:0], din_s};
  assign wr_last = (bit_idx_r == 2 * WORD_BITS - 6'd1);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= FRAME_IDLE;
      bit_idx_r <= 6'd0;
      shift_r <= 16'h0000;
      ctrl_r <= 16'h0000;
      rd_data_r <= 16'h0000;
    end else if (sclk_fall) begin
      case (state_r)
        FRAME_IDLE: begin
          if (fsync_s) begin
            shift_r <= shift_nxt;
            bit_idx_r <= 6'd1;
            state_r <= FRAME_ACTIVE;
          end
        end
        FRAME_ACTIVE: begin
          shift_r <= shift_nxt;
          bit_idx_r <= bit_idx_r + 6'd1;
          if (bit_idx_r == WORD_BITS - 6'd1) begin
            ctrl_r <= shift_nxt;
            rd_data_r <= read_word(shift_nxt[ADDR_W-1:0]);
          end
          if (bit_idx_r == FRAME_BITS - 6'd1) begin
            state_r <= FRAME_IDLE;
            bit_idx_r <= 6'd0;
          end
        end
        default: state_r <= FRAME_IDLE;
      endcase
    end
  end

  // ****************************************
  // Delayed write commit
  // ****************************************
  logic [6:0] dly_cnt_r;
  logic dly_run_r;
  logic dly_done;

  assign dly_done = dly_run_r && sclk_fall &&
                    dly_cnt_r == WRITE_DELAY_LINK_CLKS - 7'd1;
  assign apply_wr = wr_pend_r && (dly_done || fsync_fall);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dly_run_r <= 1'b0;
      dly_cnt_r <= 7'd0;
    end else if (fsync_fall) begin
      dly_run_r <= 1'b1;
      dly_cnt_r <= 7'd0;
    end else if (dly_done) begin
      dly_run_r <= 1'b0;
    end else if (dly_run_r && sclk_fall) begin
      dly_cnt_r <= dly_cnt_r + 7'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 4'h0;
      wr_data_r <= 16'h0000;
    end else if (sclk_fall && state_r == FRAME_ACTIVE && wr_last &&
                 !ctrl_r[CTRL_READ_BIT]) begin
      wr_pend_r <= 1'b1;
      wr_addr_r <= ctrl_r[ADDR_W-1:0];
      wr_data_r <= shift_nxt;
    end else if (apply_wr) begin
      wr_pend_r <= 1'b0;
    end
  end

  // ****************************************
  // Serial data out
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_data_out_pin <= 1'b0;
      serial_data_out_oe <= 1'b0;
    end else if (sclk_rise) begin
      if (state_r == FRAME_ACTIVE && bit_idx_r >= WORD_BITS &&
          bit_idx_r < 2 * WORD_BITS) begin
        serial_data_out_pin <= 1'b0;
        serial_data_out_oe <= pin_direction_r[BIT_SECOND_WORD_DRIVE_LOW];
      end else if (state_r == FRAME_ACTIVE &&
                   bit_idx_r >= 2 * WORD_BITS) begin
        serial_data_out_pin <= rd_data_r[~bit_idx_r[3:0]];
        serial_data_out_oe <= 1'b1;
      end else begin
        serial_data_out_pin <= 1'b0;
        serial_data_out_oe <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  pin_drive_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    apply_wr && wr_addr_r == ADDR_PIN_DATA |=>
      gpio_out == $past(wr_data_r[PIN_COUNT-1:0]))
    else $error("pin data write not driven");

  pin_read_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    sclk_fall && state_r == FRAME_ACTIVE &&
    bit_idx_r == WORD_BITS - 6'd1 &&
    shift_nxt[ADDR_W-1:0] == ADDR_PIN_DATA |=>
      rd_data_r == {6'h00, $past(pins_s)})
    else $error("pin read not live level");

  dir_reset_a: assert property (
    @(posedge ref_clk) $past(srst) |-> gpio_oe == '0)
    else $error("pins not inputs after reset");

  word_two_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    sclk_rise && state_r == FRAME_ACTIVE && bit_idx_r == 6'd20 |=>
      serial_data_out_pin == 1'b0 &&
      serial_data_out_oe == $past(pin_direction_r[15]))
    else $error("second word drive wrong");

  rise_set_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    |(src_vec & ~src_prev_r & rising_edge_enable_r) |=>
      (status_r & $past(rise_ev)) == $past(rise_ev))
    else $error("enabled rise not latched");

  fall_set_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    |(~src_vec & src_prev_r & falling_edge_enable_r) |=>
      (status_r & $past(fall_ev)) == $past(fall_ev))
    else $error("enabled fall not latched");

  sticky_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ##1 ($past(status_r) & ~status_r & ~$past(clr_pulse)) == 16'h0000)
    else $error("status dropped without clear");

  no_spurious_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ##1 (status_r & ~$past(status_r) &
         ~$past(rise_ev | fall_ev)) == 16'h0000)
    else $error("status set without enabled edge");

  write_delay_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    apply_wr |-> fsync_fall || dly_cnt_r == 7'd64)
    else $error("write applied at wrong time");

  unused_zero_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (rising_edge_enable_r & ~EDGE_MASK) == 16'h0000 &&
    (pin_direction_r & ~DIR_MASK) == 16'h0000)
    else $error("unused bit holds a one");

endmodule
`default_nettype wire

// File: src/gpio_edge_pkg.sv
// Constants for the pin and edge interrupt unit.
// Assumes a 16-bit register word and a three-word serial frame.
package gpio_edge_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int REG_W = 16;
  localparam int PIN_COUNT = 10;
  localparam logic [3:0] ADDR_PIN_DATA = 4'h0;
  localparam logic [3:0] ADDR_PIN_DIRECTION = 4'h1;
  localparam logic [3:0] ADDR_RISING_EDGE_ENABLE = 4'h2;
  localparam logic [3:0] ADDR_FALLING_EDGE_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_INTERRUPT_CLEAR_STATUS = 4'h4;

  // ****************************************
  // Reset values and field layout
  // ****************************************
  localparam logic [15:0] RST_PIN_DATA = 16'h0000;
  localparam logic [15:0] RST_PIN_DIRECTION = 16'h0000;
  localparam logic [15:0] RST_RISING_EDGE_ENABLE = 16'h0000;
  localparam logic [15:0] RST_FALLING_EDGE_ENABLE = 16'h0000;
  localparam logic [15:0] RST_INTERRUPT_STATUS = 16'h0000;
  localparam logic [15:0] PIN_MASK = 16'h03FF;
  localparam logic [15:0] DIR_MASK = 16'h83FF;
  localparam logic [15:0] EDGE_MASK = 16'hFBFF;
  localparam int BIT_SECOND_WORD_DRIVE_LOW = 15;
  localparam int BIT_CONV_DONE = 11;
  localparam int BIT_TOUCH_XPOS = 12;
  localparam int BIT_TOUCH_XNEG = 13;
  localparam int BIT_TEL_OVERLOAD = 14;
  localparam int BIT_SND_OVERLOAD = 15;

  // ****************************************
  // Serial frame
  // ****************************************
  localparam int CTRL_READ_BIT = 15;
  localparam logic [5:0] WORD_BITS = 6'd16;
  localparam logic [5:0] FRAME_BITS = 6'd48;
  localparam logic [6:0] WRITE_DELAY_LINK_CLKS = 7'd65;

endpackage

// File: src/sync2.sv
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);

  // ****************************************
  // Two flops per bit
  // ****************************************
  logic [WIDTH-1:0] meta_r;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        meta_r[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  end

endmodule
`default_nettype wire
